// >>> inc/fsp_if.sv
`timescale 1ns/10ps
`default_nettype none

interface fsp_if;
  logic ctrl_we;
  logic [7:0] ctrl_wdata;
  logic [7:0] ctrl_rdata;
  logic spm_req;
  logic [15:0] ptr;
  logic [15:0] data_pair;
  logic stall;

  modport device (input ctrl_we, ctrl_wdata, spm_req, ptr, data_pair, output ctrl_rdata, stall);
  modport core (output ctrl_we, ctrl_wdata, spm_req, ptr, data_pair, input ctrl_rdata, stall);
endinterface

`default_nettype wire

// >>> inc/fsp_pkg.sv
`include "fsp_regs.svh"

package fsp_pkg;
  typedef logic [15:0] fsp_word_t;
  typedef logic [`FSP_PAGE_WORDS-1:0][15:0] fsp_page_t;
  typedef enum logic [1:0] {FSP_IDLE, FSP_ERASE, FSP_WRITE} fsp_dev_state_t;
  typedef enum logic [2:0] {FSP_H_IDLE, FSP_H_CTRL, FSP_H_DELAY, FSP_H_SPM, FSP_H_HALT} fsp_host_state_t;
endpackage

// >>> inc/fsp_regs.svh
`ifndef FSP_REGS_SVH
`define FSP_REGS_SVH

`define FSP_CLK_PERIOD_NS 5
`define FSP_ARM_WINDOW 3'h4

`define FSP_OP_LOAD 5'h01
`define FSP_OP_ERASE 5'h03
`define FSP_OP_WRITE 5'h05
`define FSP_OP_CLEAR 5'h11

`define FSP_BIT_ARM 0
`define FSP_BIT_ERASE 1
`define FSP_BIT_WRITE 2

`define FSP_WORD_LSB 1
`define FSP_WORD_MSB 4
`define FSP_PAGE_LSB 5
`define FSP_PAGE_MSB 9
`define FSP_PAGE_WORDS 16
`define FSP_FLASH_WORDS 512
`define FSP_ERASED_WORD 16'hffff
`define FSP_CTRL_RESET 8'h00

`define FSP_ERASE_TIME_NS 4000
`define FSP_WRITE_TIME_NS 4000
`define FSP_ERASE_CYCLES ((`FSP_ERASE_TIME_NS + `FSP_CLK_PERIOD_NS - 1) / `FSP_CLK_PERIOD_NS)
`define FSP_WRITE_CYCLES ((`FSP_WRITE_TIME_NS + `FSP_CLK_PERIOD_NS - 1) / `FSP_CLK_PERIOD_NS)

`define FSP_ADDR_CMD 4'h0
`define FSP_ADDR_PTR 4'h4
`define FSP_ADDR_DATA 4'h8
`define FSP_ADDR_STATUS 4'hc
`define FSP_CMD_DELAY_LSB 8
`define FSP_CMD_DELAY_MSB 10
`define FSP_CMD_SKIP_BIT 11

`endif

// >>> logic/fsp_dev.sv
`timescale 1ns/10ps
`default_nettype none
`include "fsp_regs.svh"

module fsp_dev
  import fsp_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  fsp_if.device link,
  input wire logic ee_write_active,
  input wire logic [8:0] rd_addr,
  output fsp_pkg::fsp_word_t rd_data
);
  import fsp_pkg::*;

  // ***************************************
  // control register and arm window
  // ***************************************
  localparam logic [7:0] CTRL_RESET = `FSP_CTRL_RESET;
  fsp_dev_state_t state_reg;
  logic arm_reg;
  logic erase_reg;
  logic pgwr_reg;
  logic [2:0] window_reg;
  logic [9:0] busy_reg;
  logic [4:0] page_reg;
  logic [4:0] code;
  logic ctrl_ok;
  logic spm_take;
  logic op_done;
  logic buf_clear;
  logic buf_loaded;
  fsp_page_t buf_words;
  fsp_word_t flash_mem [`FSP_FLASH_WORDS];

  function automatic logic code_known(input logic [4:0] c);
    code_known = (c == `FSP_OP_LOAD) || (c == `FSP_OP_ERASE) || (c == `FSP_OP_WRITE) || (c == `FSP_OP_CLEAR);
  endfunction

  assign code = link.ctrl_wdata[4:0];
  // writes while busy or during an eeprom write are dropped outright
  assign ctrl_ok = link.ctrl_we && !ee_write_active && state_reg == FSP_IDLE && code_known(code);
  assign spm_take = link.spm_req && arm_reg && state_reg == FSP_IDLE && !ee_write_active;
  assign op_done = state_reg != FSP_IDLE && busy_reg == 10'h000;
  assign link.stall = state_reg != FSP_IDLE;
  assign link.ctrl_rdata = {3'h0, 2'h0, pgwr_reg, erase_reg, arm_reg};

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      arm_reg <= CTRL_RESET[`FSP_BIT_ARM];
      erase_reg <= CTRL_RESET[`FSP_BIT_ERASE];
      pgwr_reg <= CTRL_RESET[`FSP_BIT_WRITE];
      window_reg <= 3'h0;
    end
    else if (state_reg != FSP_IDLE)
    begin
      if (op_done)
      begin
        arm_reg <= 1'b0;
        erase_reg <= 1'b0;
        pgwr_reg <= 1'b0;
      end
    end
    else if (spm_take)
    begin
      // erase and write keep their bits until the page is done
      if (!erase_reg && !pgwr_reg)
      begin
        arm_reg <= 1'b0;
      end
    end
    else if (ctrl_ok && code != `FSP_OP_CLEAR)
    begin
      arm_reg <= 1'b1;
      erase_reg <= code[`FSP_BIT_ERASE];
      pgwr_reg <= code[`FSP_BIT_WRITE];
      window_reg <= `FSP_ARM_WINDOW;
    end
    else if (arm_reg)
    begin
      if (window_reg == 3'h1)
      begin
        arm_reg <= 1'b0;
        erase_reg <= 1'b0;
        pgwr_reg <= 1'b0;
      end
      window_reg <= window_reg - 3'h1;
    end
  end

  // ***************************************
  // erase / write sequencer
  // ***************************************
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      state_reg <= FSP_IDLE;
      busy_reg <= 10'h000;
      page_reg <= 5'h00;
    end
    else
    begin
      case (state_reg)
        FSP_IDLE:
        begin
          if (spm_take && erase_reg)
          begin
            state_reg <= FSP_ERASE;
            busy_reg <= 10'(`FSP_ERASE_CYCLES - 1);
            page_reg <= link.ptr[`FSP_PAGE_MSB:`FSP_PAGE_LSB];
          end
          else if (spm_take && pgwr_reg)
          begin
            state_reg <= FSP_WRITE;
            busy_reg <= 10'(`FSP_WRITE_CYCLES - 1);
            page_reg <= link.ptr[`FSP_PAGE_MSB:`FSP_PAGE_LSB];
          end
        end
        FSP_ERASE, FSP_WRITE:
        begin
          if (op_done)
          begin
            state_reg <= FSP_IDLE;
          end
          else
          begin
            busy_reg <= busy_reg - 10'h001;
          end
        end
        default:
        begin
          state_reg <= FSP_IDLE;
        end
      endcase
    end
  end

  // ***************************************
  // temporary page buffer
  // ***************************************
  // buffer is independent of erase, so fill order does not matter
  assign buf_clear = (ctrl_ok && code == `FSP_OP_CLEAR)
    || (op_done && state_reg == FSP_WRITE)
    || (ee_write_active && buf_loaded && state_reg == FSP_IDLE);

  fsp_page_buf u_buf (
    .ref_clk(ref_clk),
    .rst(rst),
    .clear(buf_clear),
    .wr_en(spm_take && !erase_reg && !pgwr_reg),
    .wr_idx(link.ptr[`FSP_WORD_MSB:`FSP_WORD_LSB]),
    .wr_data(link.data_pair),
    .words(buf_words),
    .loaded(buf_loaded)
  );

  // ***************************************
  // program memory array
  // ***************************************
  // programming can only clear bits, so an unerased page corrupts
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      for (int i = 0; i < `FSP_FLASH_WORDS; i++)
      begin
        flash_mem[i] <= `FSP_ERASED_WORD;
      end
      rd_data <= 16'h0000;
    end
    else
    begin
      if (op_done && state_reg == FSP_ERASE)
      begin
        for (int w = 0; w < `FSP_PAGE_WORDS; w++)
        begin
          flash_mem[{page_reg, 4'(w)}] <= `FSP_ERASED_WORD;
        end
      end
      else if (op_done && state_reg == FSP_WRITE)
      begin
        for (int w = 0; w < `FSP_PAGE_WORDS; w++)
        begin
          flash_mem[{page_reg, 4'(w)}] <= flash_mem[{page_reg, 4'(w)}] & buf_words[w];
        end
      end
      rd_data <= flash_mem[rd_addr];
    end
  end
endmodule

`default_nettype wire

// >>> logic/fsp_host.sv
// The AXI4-Lite interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "fsp_regs.svh"

module fsp_host
  import fsp_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  fsp_if.core link,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [3:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp
);
  import fsp_pkg::*;

  // ***************************************
  // axi4-lite slave
  // ***************************************
  fsp_host_state_t state_reg;
  logic aw_hold_reg;
  logic w_hold_reg;
  logic [3:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic [31:0] cmd_reg;
  logic [2:0] delay_reg;
  logic do_write;
  logic [31:0] cmd_merged;
  logic [31:0] ptr_merged;
  logic [31:0] data_merged;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
    for (int b = 0; b < 4; b++)
    begin
      merge[b*8 +: 8] = strb[b] ? nw[b*8 +: 8] : old[b*8 +: 8];
    end
  endfunction

  assign s_axi_awready = !aw_hold_reg && !s_axi_bvalid;
  assign s_axi_wready = !w_hold_reg && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign s_axi_bresp = 2'h0;
  assign s_axi_rresp = 2'h0;
  assign do_write = aw_hold_reg && w_hold_reg && !s_axi_bvalid;
  assign cmd_merged = merge(cmd_reg, w_data_reg, w_strb_reg);
  assign ptr_merged = merge({16'h0000, link.ptr}, w_data_reg, w_strb_reg);
  assign data_merged = merge({16'h0000, link.data_pair}, w_data_reg, w_strb_reg);

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      aw_hold_reg <= 1'b0;
      w_hold_reg <= 1'b0;
      aw_addr_reg <= 4'h0;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
      s_axi_bvalid <= 1'b0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_hold_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_hold_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (do_write)
      begin
        aw_hold_reg <= 1'b0;
        w_hold_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
      end
      else if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      case (s_axi_araddr)
        `FSP_ADDR_CMD: s_axi_rdata <= cmd_reg;
        `FSP_ADDR_PTR: s_axi_rdata <= {16'h0000, link.ptr};
        `FSP_ADDR_DATA: s_axi_rdata <= {16'h0000, link.data_pair};
        `FSP_ADDR_STATUS: s_axi_rdata <= {16'h0000, link.ctrl_rdata, 6'h00, link.stall, state_reg != FSP_H_IDLE};
        default: s_axi_rdata <= 32'h0000_0000;
      endcase
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ***************************************
  // pointer and data registers
  // ***************************************
  // software must give erase and write the same page
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      link.ptr <= 16'h0000;
      link.data_pair <= 16'h0000;
    end
    else if (do_write && aw_addr_reg == `FSP_ADDR_PTR)
    begin
      link.ptr <= ptr_merged[15:0];
    end
    else if (do_write && aw_addr_reg == `FSP_ADDR_DATA)
    begin
      link.data_pair <= data_merged[15:0];
    end
  end

  // ***************************************
  // control write then store sequencer
  // ***************************************
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      state_reg <= FSP_H_IDLE;
      cmd_reg <= 32'h0000_0000;
      delay_reg <= 3'h0;
      link.ctrl_we <= 1'b0;
      link.ctrl_wdata <= 8'h00;
      link.spm_req <= 1'b0;
    end
    else
    begin
      case (state_reg)
        FSP_H_IDLE:
        begin
          // a command while a sequence runs is dropped
          if (do_write && aw_addr_reg == `FSP_ADDR_CMD)
          begin
            cmd_reg <= cmd_merged;
            link.ctrl_we <= 1'b1;
            link.ctrl_wdata <= {3'h0, cmd_merged[4:0]};
            state_reg <= FSP_H_CTRL;
          end
        end
        FSP_H_CTRL:
        begin
          link.ctrl_we <= 1'b0;
          delay_reg <= cmd_reg[`FSP_CMD_DELAY_MSB:`FSP_CMD_DELAY_LSB];
          state_reg <= cmd_reg[`FSP_CMD_SKIP_BIT] ? FSP_H_IDLE : FSP_H_DELAY;
        end
        FSP_H_DELAY:
        begin
          if (delay_reg == 3'h0)
          begin
            link.spm_req <= 1'b1;
            state_reg <= FSP_H_SPM;
          end
          else
          begin
            delay_reg <= delay_reg - 3'h1;
          end
        end
        FSP_H_SPM:
        begin
          link.spm_req <= 1'b0;
          state_reg <= FSP_H_HALT;
        end
        FSP_H_HALT:
        begin
          if (!link.stall)
          begin
            state_reg <= FSP_H_IDLE;
          end
        end
        default:
        begin
          state_reg <= FSP_H_IDLE;
        end
      endcase
    end
  end
endmodule

`default_nettype wire

// >>> logic/fsp_page_buf.sv
`timescale 1ns/10ps
`default_nettype none
`include "fsp_regs.svh"

module fsp_page_buf
  import fsp_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clear,
  input wire logic wr_en,
  input wire logic [3:0] wr_idx,
  input wire fsp_pkg::fsp_word_t wr_data,
  output fsp_pkg::fsp_page_t words,
  output logic loaded
);
  import fsp_pkg::*;

  logic [`FSP_PAGE_WORDS-1:0] valid_reg;

  assign loaded = |valid_reg;

  genvar g;
  generate
    for (g = 0; g < `FSP_PAGE_WORDS; g++)
    begin : g_word
      always_ff @(posedge ref_clk or posedge rst)
      begin
        if (rst)
        begin
          words[g] <= `FSP_ERASED_WORD;
          valid_reg[g] <= 1'b0;
        end
        else if (clear)
        begin
          words[g] <= `FSP_ERASED_WORD;
          valid_reg[g] <= 1'b0;
        end
        // a second load of a word is dropped, not merged
        else if (wr_en && wr_idx == 4'(g) && !valid_reg[g])
        begin
          words[g] <= wr_data;
          valid_reg[g] <= 1'b1;
        end
      end
    end
  endgenerate
endmodule

`default_nettype wire

// >>> verif/fsp_link_chk.sv
`timescale 1ns/10ps
`default_nettype none
`include "fsp_regs.svh"
// ****
// link checker
// ****
module fsp_link_chk
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ctrl_we,
  input wire logic [7:0] ctrl_wdata,
  input wire logic [7:0] ctrl_rdata,
  input wire logic spm_req,
  input wire logic [15:0] ptr,
  input wire logic [15:0] data_pair,
  input wire logic stall,
  input wire logic ee_write_active
);
  localparam int STALL_CYC = `FSP_ERASE_CYCLES;
  logic [15:0] run_cnt;
  logic cmd_ok;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  assign cmd_ok = ctrl_we && !stall && !ee_write_active;
  // too long for a repetition count, so counted here
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      run_cnt <= 16'h0;
    else if (stall)
      run_cnt <= run_cnt + 16'h1;
    else
      run_cnt <= 16'h0;
  end
  sequence op_go;
    spm_req && ctrl_rdata[0] && (ctrl_rdata[2:1] != 2'b00) && !stall && !ee_write_active;
  endsequence
  sequence arm_idle;
    $rose(ctrl_rdata[0]) ##0 (!spm_req) [*4];
  endsequence
  chk_arm_set:
    assert property (cmd_ok && ctrl_wdata[4:0] inside {5'h01, 5'h03, 5'h05}
      |=> ctrl_rdata[2:0] == $past(ctrl_wdata[2:0])) else $error("command bits not armed");
  chk_undef_code:
    assert property (cmd_ok && !ctrl_rdata[0] && !(ctrl_wdata[4:0] inside {5'h01, 5'h03, 5'h05})
      |=> ctrl_rdata[2:0] == 3'b000) else $error("undefined code changed control");
  chk_arm_window:
    assert property (arm_idle |=> !ctrl_rdata[0]) else $error("arm outlived its window");
  chk_load_done:
    assert property (spm_req && ctrl_rdata[2:0] == 3'b001 && !stall && !ee_write_active
      |=> !ctrl_rdata[0] && !stall) else $error("load did not release arm");
  chk_op_start:
    assert property (op_go |=> stall) else $error("core not stalled on operation");
  chk_stall_len:
    assert property ($fell(stall) |-> run_cnt == STALL_CYC) else $error("stall length wrong");
  chk_arm_held:
    assert property (stall |-> ctrl_rdata[0] && (ctrl_rdata[1] != ctrl_rdata[2]))
      else $error("arm dropped during operation");
  chk_op_clear:
    assert property ($fell(stall) |-> ctrl_rdata[2:0] == 3'b000) else $error("bits left after operation");
  chk_ee_block:
    assert property (ee_write_active && !stall |=> !stall) else $error("operation during eeprom write");
endmodule
`default_nettype wire

// >>> verif/test_flash_self_program_ctrl.sv
`timescale 1ns/10ps
`default_nettype none
`include "fsp_regs.svh"
// ****
// bench
// ****
module test_flash_self_program_ctrl;
  import fsp_pkg::*;
  logic ref_clk, rst, ee_write_active, fl_vld;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [8:0] rd_addr;
  fsp_word_t rd_data;
  fsp_word_t mem_m [512];
  fsp_word_t buf_m [16];
  logic [31:0] exp_q [$];
  logic [4:0] bad_codes [4] = '{5'h02, 5'h07, 5'h09, 5'h1f};
  int error_cnt, comparisons, cyc;
  fsp_if fi();
  fsp_dev fsp_dev_inst(.ref_clk(ref_clk), .rst(rst), .link(fi), .ee_write_active(ee_write_active),
    .rd_addr(rd_addr), .rd_data(rd_data));
  fsp_host fsp_host_inst(.ref_clk(ref_clk), .rst(rst), .link(fi), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_awaddr(s_axi_awaddr), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_araddr(s_axi_araddr),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp));
  fsp_link_chk fsp_link_chk_inst(.ref_clk(ref_clk), .rst(rst), .ctrl_we(fi.ctrl_we), .ctrl_wdata(fi.ctrl_wdata),
    .ctrl_rdata(fi.ctrl_rdata), .spm_req(fi.spm_req), .ptr(fi.ptr), .data_pair(fi.data_pair), .stall(fi.stall),
    .ee_write_active(ee_write_active));
  initial
  begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  task automatic summarize();
    if (error_cnt == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] got);
    logic [31:0] e;
    e = exp_q.pop_front();
    comparisons++;
    if (got !== e)
    begin
      error_cnt++;
      $display("[FAIL] %0t got %h exp %h", $time, got, e);
    end
  endtask
  // watcher: oldest note against each result
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      error_cnt++;
      summarize();
    end
    if (s_axi_bvalid && s_axi_bready)
      check({30'h0, s_axi_bresp});
    if (s_axi_rvalid && s_axi_rready)
    begin
      check({30'h0, s_axi_rresp});
      check(s_axi_rdata);
    end
    if (fl_vld)
      check({16'h0, rd_data});
  end
  task automatic axw(input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    exp_q.push_back(32'h0);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge ref_clk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
  endtask
  task automatic axr(input logic [3:0] a, input logic [31:0] e);
    @(posedge ref_clk);
    exp_q.push_back(32'h0);
    exp_q.push_back(e);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge ref_clk);
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
  endtask
  // store follows d cycles later; d of 3 misses the arm
  task automatic cmd(input logic [4:0] code, input logic [2:0] d);
    axw(`FSP_ADDR_CMD, {20'h0, 1'b0, d, 3'h0, code});
    repeat (8) @(posedge ref_clk);
  endtask
  task automatic ld(input logic [4:0] pg, input logic [3:0] idx, input fsp_word_t v, input logic [2:0] d,
    input logic eff);
    axw(`FSP_ADDR_PTR, {22'h0, pg, idx, 1'b0});
    axw(`FSP_ADDR_DATA, {16'h0, v});
    axr(`FSP_ADDR_DATA, {16'h0, v});
    cmd(`FSP_OP_LOAD, d);
    if (eff)
      buf_m[idx] = v;
  endtask
  task automatic op(input logic [4:0] code, input logic [4:0] pg, input logic eff);
    axw(`FSP_ADDR_PTR, {22'h0, pg, 5'h0});
    axr(`FSP_ADDR_PTR, {22'h0, pg, 5'h0});
    cmd(code, 3'h0);
    // sampled while the core is held: arm and op bits must still stand
    axr(`FSP_ADDR_STATUS, eff ? {16'h0, 5'h0, code[2:0], 6'h0, 2'b11} : 32'h0);
    while (fi.stall) @(posedge ref_clk);
    for (int i = 0; i < 16; i++)
    begin
      if (eff && code == `FSP_OP_ERASE)
        mem_m[{pg, i[3:0]}] = `FSP_ERASED_WORD;
      if (eff && code == `FSP_OP_WRITE)
      begin
        mem_m[{pg, i[3:0]}] &= buf_m[i];
        buf_m[i] = `FSP_ERASED_WORD;
      end
    end
  endtask
  task automatic chk_page(input logic [4:0] pg);
    for (int i = 0; i < 16; i++)
    begin
      @(posedge ref_clk);
      rd_addr <= {pg, i[3:0]};
      exp_q.push_back({16'h0, mem_m[{pg, i[3:0]}]});
      @(posedge ref_clk);
      fl_vld <= 1'b1;
      @(posedge ref_clk);
      fl_vld <= 1'b0;
    end
  endtask
  initial
  begin
    logic [3:0] perm [16];
    logic [3:0] t;
    int j;
    rst = 1'b1;
    {ee_write_active, fl_vld, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, rd_addr} = '0;
    s_axi_wstrb = 4'hf;
    void'($urandom(32'h99c6));
    foreach (mem_m[k]) mem_m[k] = `FSP_ERASED_WORD;
    foreach (buf_m[k])
    begin
      buf_m[k] = `FSP_ERASED_WORD;
      perm[k] = k[3:0];
    end
    for (int i = 15; i > 0; i--)
    begin
      j = $urandom_range(i);
      t = perm[i];
      perm[i] = perm[j];
      perm[j] = t;
    end
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    chk_page(5'd3);
    op(`FSP_OP_ERASE, 5'd3, 1'b1);
    for (int i = 0; i < 16; i++) ld(5'd3, perm[i], 16'($urandom), 3'($urandom_range(2)), 1'b1);
    op(`FSP_OP_WRITE, 5'd3, 1'b1);
    chk_page(5'd3);
    // one word changes, the rest is carried through the buffer
    j = $urandom_range(15);
    for (int i = 0; i < 16; i++)
    begin
      ld(5'd3, i[3:0], (i == j) ? 16'($urandom) : mem_m[{5'd3, i[3:0]}], 3'h1, 1'b1);
    end
    op(`FSP_OP_ERASE, 5'd3, 1'b1);
    chk_page(5'd3);
    op(`FSP_OP_WRITE, 5'd3, 1'b1);
    chk_page(5'd3);
    for (int i = 0; i < 16; i++) ld(5'd31, i[3:0], 16'($urandom), 3'h2, 1'b1);
    op(`FSP_OP_ERASE, 5'd31, 1'b1);
    op(`FSP_OP_WRITE, 5'd31, 1'b1);
    chk_page(5'd31);
    op(`FSP_OP_WRITE, 5'd8, 1'b1);
    chk_page(5'd8);
    ld(5'd10, 4'd0, 16'($urandom), 3'h0, 1'b1);
    ld(5'd10, 4'd1, 16'($urandom), 3'h1, 1'b1);
    cmd(`FSP_OP_CLEAR, 3'h0);
    axr(`FSP_ADDR_CMD, {27'h0, `FSP_OP_CLEAR});
    foreach (buf_m[k]) buf_m[k] = `FSP_ERASED_WORD;
    op(`FSP_OP_WRITE, 5'd10, 1'b1);
    chk_page(5'd10);
    ld(5'd11, 4'd5, 16'($urandom), 3'h0, 1'b1);
    ee_write_active <= 1'b1;
    repeat (3) @(posedge ref_clk);
    ee_write_active <= 1'b0;
    foreach (buf_m[k]) buf_m[k] = `FSP_ERASED_WORD;
    // late store and skipped store must both leave the buffer alone
    ld(5'd11, 4'd2, 16'($urandom), 3'h3, 1'b0);
    axw(`FSP_ADDR_PTR, {22'h0, 5'd11, 4'd9, 1'b0});
    axw(`FSP_ADDR_CMD, {20'h0, 1'b1, 3'h0, 3'h0, `FSP_OP_LOAD});
    repeat (8) @(posedge ref_clk);
    ld(5'd11, 4'd7, 16'($urandom), 3'h0, 1'b1);
    op(`FSP_OP_WRITE, 5'd11, 1'b1);
    chk_page(5'd11);
    ee_write_active <= 1'b1;
    op(`FSP_OP_ERASE, 5'd3, 1'b0);
    ee_write_active <= 1'b0;
    chk_page(5'd3);
    foreach (bad_codes[k])
    begin
      cmd(bad_codes[k], 3'h0);
      axr(`FSP_ADDR_STATUS, 32'h0);
    end
    summarize();
  end
endmodule
`default_nettype wire
